// file: rtl/sp_slot.sv
// Purpose: one stack pointer storage word
// Assumes: write enable from the bank owner
// Notes: no reset, content is undefined after start-up
`timescale 1ns/10ps
module sp_slot import stack_pkg::*; #(
  parameter int WIDTH = SP_W
) (
  input wire logic sys_clk,
  input wire logic we,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  always_ff @(posedge sys_clk) begin
    if (we) begin
      q <= d;
    end
  end
endmodule // sp_slot

// file: rtl/stack_pkg.sv
// Purpose: shared types and constants of the stack pointer bank
// Assumes: one 200 MHz clock, AXI4-Lite register access
// Notes: pointer index equals {interruptStackFlag, currentModeField}
//
// Behaviour
// - one pointer per state; on state change save stack register, reload new one
// - flag 1 mode 0 picks interrupt pointer; flag 0 modes pick process pointers
// - entry clears mode bits so mode is never non-zero on interrupt stack
// - return loading flag and non-zero mode raises reserved operand fault instead
// - entry uses interrupt stack if flag set or code 01, else kernel
// - vector codes 10 and 11 never select kernel or interrupt stack
// - kernel stack fault aborts, starts kernel-stack-not-valid abort at level 1F
// - interrupt stack fault halts the processor, no further exception processing
// - recurring kernel or interrupt stack faults never loop endlessly
// - no stack alignment except for the two call instructions
// - privileged register access reads and writes all five pointers, current included
// - all five pointers may live in internal registers
// - pointer register number equals status bits 26:24
// - previous mode bits 23:22 cleared on interrupt entry
// - pointers need no reset value
// - code 0 kernel unless on interrupt stack; code 1 interrupt, level 1F on exceptions
package stack_pkg;
  localparam int SP_W = 32;
  localparam int ADDR_W = 8;
  localparam int NUM_SP = 5;
  localparam logic [1:0] MODE_KERNEL = 2'h0;
  localparam logic [2:0] IDX_INTERRUPT = 3'h4;
  localparam logic [1:0] VEC_KERNEL = 2'h0;
  localparam logic [1:0] VEC_INTERRUPT = 2'h1;
  localparam logic [4:0] LEVEL_TOP = 5'h1F;
  // register map, byte addresses
  localparam logic [ADDR_W-1:0] REG_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] REG_STATE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_EVT_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] REG_EVT_MASK = 8'h0C;
  localparam logic [2:0] SP_PAGE = 3'h1;
  // field positions of the state word
  localparam int POS_FLAG = 26;
  localparam int POS_CUR = 24;
  localparam int POS_PRV = 22;
  localparam int POS_HALT = 8;
  localparam int POS_KSNV = 9;
  // event bits
  localparam int EVT_W = 4;
  localparam int EVT_ROF = 0;
  localparam int EVT_KSNV = 1;
  localparam int EVT_HALT = 2;
  localparam int EVT_DIVERT = 3;
  localparam int CTRL_HALT_CLR = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic interruptStackFlag;
    logic [1:0] currentModeField;
    logic [1:0] previousModeField;
    logic [4:0] priorityLevel;
  } status_longword_t;

  typedef enum logic [1:0] {OP_NONE, OP_EXCEPTION, OP_INTERRUPT, OP_RETURN} seq_op_t;

  typedef struct packed {
    logic valid;
    seq_op_t op;
    logic [1:0] vecCode;
    logic [4:0] newLevel;
    status_longword_t retWord;
  } seq_req_t;
endpackage

// file: rtl/stack_pointer_select.sv
// Purpose: stack pointer bank, selection, swap and stack fault escalation
// Assumes: sequencer requests on the same clock, AXI4-Lite privileged access
// Notes: bus writes stall while the sequencer changes state
//
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module stack_pointer_select import stack_pkg::*; (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire seq_req_t seqReq,
  input wire logic stackFault,
  input wire logic regFourteenWe,
  input wire logic [SP_W-1:0] regFourteenWdata,
  input wire logic callAlign,
  output logic [SP_W-1:0] generalRegFourteen,
  output status_longword_t statusWord,
  output logic entryDone,
  output logic rsvdOperandFault,
  output logic ksnvAbort,
  output logic haltReq,
  output logic vecDiverted,
  output logic irq
);
  // ==========================================================
  // state
  status_longword_t word_q, word_d;
  logic [SP_W-1:0] gr_q, gr_d;
  logic ksnv_q, ksnv_d, halt_q, halt_d;
  logic [EVT_W-1:0] evtStat_q, evtMask_q, evtSet;
  logic [SP_W-1:0] bankQ [NUM_SP];
  logic bankWe;
  logic [2:0] bankWIdx;
  logic [SP_W-1:0] bankWData;
  logic awHeld_q, wHeld_q;
  logic [ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;

  // ==========================================================
  // pointer bank
  for (genvar g = 0; g < NUM_SP; g++) begin : gSlot
    sp_slot #(.WIDTH(SP_W)) uSlot (
      .sys_clk(sys_clk),
      .we(bankWe && (bankWIdx == 3'(g))),
      .d(bankWData),
      .q(bankQ[g])
    );
  end

  // ==========================================================
  // selection and next state
  wire [2:0] curIdx = {word_q.interruptStackFlag, word_q.currentModeField};
  wire seqFire = seqReq.valid && !halt_q;
  wire faultFire = stackFault && !halt_q;
  wire onIntStack = word_q.interruptStackFlag || ksnv_q;
  wire faultHalt = faultFire && onIntStack;
  wire faultKsnv = faultFire && !onIntStack && (word_q.currentModeField == MODE_KERNEL);
  wire isEntry = seqFire && (seqReq.op == OP_EXCEPTION || seqReq.op == OP_INTERRUPT);
  wire vecStack = (seqReq.vecCode == VEC_KERNEL) || (seqReq.vecCode == VEC_INTERRUPT);
  wire entryGo = isEntry && vecStack && !faultFire;
  wire divertGo = isEntry && !vecStack && !faultFire;
  wire retBad = seqReq.retWord.interruptStackFlag && (seqReq.retWord.currentModeField != MODE_KERNEL);
  wire retFire = seqFire && (seqReq.op == OP_RETURN) && !faultFire;
  wire retGo = retFire && !retBad;
  wire retRof = retFire && retBad;
  wire toIntr = word_q.interruptStackFlag || (seqReq.vecCode == VEC_INTERRUPT);

  always_comb begin
    word_d = word_q;
    if (faultKsnv) begin
      word_d.interruptStackFlag = 1'b1;
      word_d.currentModeField = MODE_KERNEL;
      word_d.priorityLevel = LEVEL_TOP;
    end else if (entryGo) begin
      word_d.interruptStackFlag = toIntr;
      word_d.currentModeField = MODE_KERNEL;
      if (seqReq.op == OP_INTERRUPT) begin
        word_d.previousModeField = MODE_KERNEL;
        word_d.priorityLevel = seqReq.newLevel;
      end else begin
        word_d.previousModeField = word_q.currentModeField;
        if (seqReq.vecCode == VEC_INTERRUPT) begin
          word_d.priorityLevel = LEVEL_TOP;
        end
      end
    end else if (retGo) begin
      word_d = seqReq.retWord;
    end
  end

  wire stateChange = faultKsnv || entryGo || retGo;
  wire [2:0] newIdx = {word_d.interruptStackFlag, word_d.currentModeField};
  wire swap = stateChange && (newIdx != curIdx);

  // ==========================================================
  // register bus decode
  wire axiStall = seqFire || faultFire || regFourteenWe || callAlign;
  wire writeGo = awHeld_q && wHeld_q && !s_axi_bvalid && !axiStall;
  wire [2:0] wIdx = awAddr_q[4:2];
  wire [2:0] rIdx = s_axi_araddr[4:2];
  wire wIsSp = (awAddr_q[ADDR_W-1:5] == SP_PAGE) && (wIdx < 3'(NUM_SP));
  wire rIsSp = (s_axi_araddr[ADDR_W-1:5] == SP_PAGE) && (rIdx < 3'(NUM_SP));
  wire wIsCtrl = awAddr_q[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2];
  wire wIsStat = awAddr_q[ADDR_W-1:2] == REG_EVT_STAT[ADDR_W-1:2];
  wire wIsMask = awAddr_q[ADDR_W-1:2] == REG_EVT_MASK[ADDR_W-1:2];
  wire wMapped = wIsSp || wIsCtrl || wIsStat || wIsMask;
  wire rIsState = s_axi_araddr[ADDR_W-1:2] == REG_STATE[ADDR_W-1:2];
  wire rIsStat = s_axi_araddr[ADDR_W-1:2] == REG_EVT_STAT[ADDR_W-1:2];
  wire rIsMask = s_axi_araddr[ADDR_W-1:2] == REG_EVT_MASK[ADDR_W-1:2];
  wire rIsCtrl = s_axi_araddr[ADDR_W-1:2] == REG_CTRL[ADDR_W-1:2];
  wire rMapped = rIsSp || rIsState || rIsStat || rIsMask || rIsCtrl;
  wire spWrite = writeGo && wIsSp;
  wire spWriteCur = spWrite && (wIdx == curIdx);

  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  wire [SP_W-1:0] spOld = (wIdx == curIdx) ? gr_q : bankQ[wIdx];
  wire [SP_W-1:0] spMerged = mergeStrb(spOld, wData_q, wStrb_q);
  wire [31:0] stateRd = (32'(word_q.interruptStackFlag) << POS_FLAG)
    | (32'(word_q.currentModeField) << POS_CUR) | (32'(word_q.previousModeField) << POS_PRV)
    | 32'(word_q.priorityLevel) | (32'(halt_q) << POS_HALT) | (32'(ksnv_q) << POS_KSNV);
  wire [31:0] spRd = (rIdx == curIdx) ? gr_q : bankQ[rIdx];
  wire [31:0] rdMux = rIsSp ? spRd : rIsState ? stateRd : rIsStat ? 32'(evtStat_q)
    : rIsMask ? 32'(evtMask_q) : 32'h0000_0000;

  // ==========================================================
  // bank write port and stack register
  assign bankWe = swap || (spWrite && !spWriteCur);
  assign bankWIdx = swap ? curIdx : wIdx;
  assign bankWData = swap ? gr_q : spMerged;

  always_comb begin
    gr_d = gr_q;
    if (swap) begin
      gr_d = bankQ[newIdx];
    end else if (regFourteenWe) begin
      gr_d = regFourteenWdata;
    end else if (callAlign) begin
      gr_d = {gr_q[SP_W-1:2], 2'h0};
    end else if (spWriteCur) begin
      gr_d = spMerged;
    end
  end

  assign halt_d = faultHalt || (halt_q && !(writeGo && wIsCtrl && wStrb_q[0]
    && wData_q[CTRL_HALT_CLR]));
  assign ksnv_d = faultKsnv || (ksnv_q && !retGo);
  assign evtSet = {divertGo, faultHalt, faultKsnv, retRof};
  wire [EVT_W-1:0] evtClr = (writeGo && wIsStat && wStrb_q[0]) ? wData_q[EVT_W-1:0] : '0;
  wire [EVT_W-1:0] evtStat_d = (evtStat_q & ~evtClr) | evtSet;
  // mask write reaches irq at the same edge as the mask itself
  wire [EVT_W-1:0] evtMask_d = (writeGo && wIsMask && wStrb_q[0]) ? wData_q[EVT_W-1:0]
    : evtMask_q;

  // ==========================================================
  // processor state flops
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      word_q <= '0;
      gr_q <= '0;
      ksnv_q <= 1'b0;
      halt_q <= 1'b0;
    end else begin
      word_q <= word_d;
      gr_q <= gr_d;
      ksnv_q <= ksnv_d;
      halt_q <= halt_d;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      entryDone <= 1'b0;
      rsvdOperandFault <= 1'b0;
      ksnvAbort <= 1'b0;
      vecDiverted <= 1'b0;
    end else begin
      entryDone <= entryGo || faultKsnv;
      rsvdOperandFault <= retRof;
      ksnvAbort <= faultKsnv;
      vecDiverted <= divertGo;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evtStat_q <= '0;
      evtMask_q <= '0;
      irq <= 1'b0;
    end else begin
      evtStat_q <= evtStat_d;
      evtMask_q <= evtMask_d;
      irq <= |(evtStat_d & evtMask_d);
    end
  end

  assign generalRegFourteen = gr_q;
  assign statusWord = word_q;
  assign haltReq = halt_q;

  // ==========================================================
  // bus write channel
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (writeGo) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // bus read channel
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rdMux;
      s_axi_rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  AST_SAVE_OLD: assert property (swap |=> bankQ[$past(curIdx)] == $past(gr_q))
    else $error("old pointer not saved on state change");
  AST_LOAD_NEW: assert property (swap |-> ##1 generalRegFourteen == $past(bankQ[newIdx]))
    else $error("stack register not reloaded from new pointer");
  AST_SELECT: assert property (rIsSp && rIdx == curIdx
    && s_axi_arvalid && s_axi_arready |=> s_axi_rdata == $past(gr_q))
    else $error("current pointer read did not return stack register");
  AST_NO_MODE_ON_INT: assert property (statusWord.interruptStackFlag
    |-> statusWord.currentModeField == MODE_KERNEL)
    else $error("non-zero mode on interrupt stack");
  AST_RET_REJECT: assert property (retRof |=> rsvdOperandFault && $stable(statusWord))
    else $error("bad return word was loaded");
  AST_ENTRY_STACK: assert property (entryGo |=> statusWord.interruptStackFlag
    == ($past(word_q.interruptStackFlag) || $past(seqReq.vecCode) == VEC_INTERRUPT))
    else $error("wrong stack chosen on entry");
  AST_DIVERT: assert property (divertGo |=> $stable(statusWord) && vecDiverted)
    else $error("codes 10 or 11 changed the stack");
  AST_KSNV: assert property (faultKsnv |=> ksnvAbort && statusWord.interruptStackFlag
    && statusWord.priorityLevel == LEVEL_TOP ##1 !ksnvAbort)
    else $error("kernel stack fault not escalated");
  AST_HALT: assert property (faultHalt |=> haltReq && $stable(statusWord))
    else $error("interrupt stack fault did not halt");
  AST_NO_LOOP: assert property (ksnv_q && faultFire |=> haltReq && !ksnvAbort)
    else $error("repeated stack fault looped");
  // back to back entries keep the pulse high, so the second cycle follows the request
  AST_ENTRY_DONE: assert property (entryGo |=> entryDone
    ##1 (entryDone == $past(entryGo || faultKsnv)))
    else $error("entry completion pulse missing");
  AST_IRQ: assert property (irq == |(evtStat_q & evtMask_q))
    else $error("interrupt output disagrees with status and mask");
  AST_ALIGN: assert property (callAlign && !stateChange && !regFourteenWe
    |=> generalRegFourteen == {$past(gr_q[SP_W-1:2]), 2'h0})
    else $error("call alignment did not clear the low bits");
  AST_WRITE_CUR: assert property (writeGo && wIsSp && wIdx == curIdx
    && wStrb_q == 4'hF |=> generalRegFourteen == $past(wData_q))
    else $error("write to the current pointer missed the stack register");
  AST_HALT_HOLD: assert property (haltReq |=> $stable(statusWord))
    else $error("state changed while halted");
  AST_ROF_ONLY: assert property (rsvdOperandFault |-> $past(retRof))
    else $error("reserved operand pulse without a bad return");

  COV_ENTRY_INT: cover property (entryGo && seqReq.vecCode == VEC_INTERRUPT);
  COV_RETURN: cover property (retGo && swap);
  COV_KSNV: cover property (faultKsnv);
  COV_HALT: cover property (faultHalt ##1 haltReq);
  COV_DIVERT: cover property (divertGo ##1 vecDiverted);
endmodule // stack_pointer_select

// file: test/seq_model.sv
// Purpose: sequencer side model that issues state changes and stack events
// Assumes: shares sys_clk with the bank, launches just after a rising edge
// Notes: every strobe is a one-cycle pulse, released lines show inverted payload
`timescale 1ns/10ps
module seq_model import stack_pkg::*; (
  input wire logic sys_clk,
  input wire logic entryDone,
  output seq_req_t seqReq,
  output logic stackFault,
  output logic regFourteenWe,
  output logic [SP_W-1:0] regFourteenWdata,
  output logic callAlign
);
  int pushCount;
  initial begin
    seqReq = '0;
    stackFault = 1'b0;
    regFourteenWe = 1'b0;
    regFourteenWdata = '0;
    callAlign = 1'b0;
    pushCount = 0;
  end
  // pushes onto the new stack start only once entry completion is reported on entryDone
  always @(posedge sys_clk) begin
    if (entryDone === 1'b1) pushCount <= pushCount + 1;
  end
  task automatic send(input seq_req_t r);
    @(posedge sys_clk);
    seqReq <= r;
    @(posedge sys_clk);
    seqReq <= ~r;
  endtask
  // k: bit0 stack fault, bit1 stack register write, bit2 call alignment
  task automatic pulse(input logic [2:0] k, input logic [SP_W-1:0] d);
    @(posedge sys_clk);
    stackFault <= k[0];
    regFourteenWe <= k[1];
    callAlign <= k[2];
    regFourteenWdata <= d;
    @(posedge sys_clk);
    stackFault <= 1'b0;
    regFourteenWe <= 1'b0;
    callAlign <= 1'b0;
    regFourteenWdata <= ~d;
  endtask
endmodule // seq_model

// file: test/stack_pointer_select_bench.sv
// Purpose: self-checking bench of the stack pointer bank
// Assumes: 200 MHz sys_clk, AXI4-Lite master tasks, sequencer model sq
// Notes: table rows walk state changes, hand tests cover faults and events
`timescale 1ns/10ps
module stack_pointer_select_bench import stack_pkg::*;;
  typedef struct packed {
    logic we;
    logic [31:0] wd;
    seq_op_t op;
    logic [1:0] vec;
    logic [4:0] lvl;
    logic [9:0] ret;
    logic [9:0] es;
    logic [31:0] executive_stack_ptr;
    logic [2:0] ep;
  } row_t;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, generalRegFourteen, regFourteenWdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, stackFault, regFourteenWe, callAlign, entryDone, rsvdOperandFault;
  logic ksnvAbort, haltReq, vecDiverted, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  seq_req_t seqReq;
  status_longword_t statusWord;
  row_t rows [11];
  wire [2:0] pulseBits = {entryDone, rsvdOperandFault, vecDiverted};
  int bad_count = 0;
  int comparisons = 0;
  always #2.5 sys_clk = ~sys_clk;
  seq_model sq (.sys_clk, .entryDone, .seqReq, .stackFault, .regFourteenWe,
    .regFourteenWdata, .callAlign);
  stack_pointer_select dut (.sys_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .seqReq, .stackFault, .regFourteenWe,
    .regFourteenWdata, .callAlign, .generalRegFourteen, .statusWord, .entryDone,
    .rsvdOperandFault, .ksnvAbort, .haltReq, .vecDiverted, .irq);
  // ==========
  // checking and closing
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hang(input logic miss);
    if (miss) begin
      bad_count++;
      $display("mismatch bus answer expected within 50 cycles seen none");
      give_verdict();
    end
  endtask
  function automatic seq_req_t rq(seq_op_t o, logic [1:0] v, logic [4:0] l, logic [9:0] w);
    return {1'b1, o, v, l, w};
  endfunction
  // ==========
  // register bus master
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    hang(s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(er), 32'(s_axi_bresp));
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    hang(s_axi_rvalid !== 1'b1);
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", 32'(er), 32'(s_axi_rresp));
  endtask
  // ==========
  // main sequence
  initial begin
    // pointers: kernel 1000, exec 2000, super 3000, user 4000, interrupt 5000
    rows[0] = '{1'b0, 32'h0, OP_RETURN, 2'h0, 5'h00, 10'h180, 10'h180, 32'h4000, 3'h0};
    rows[1] = '{1'b1, 32'h4444, OP_EXCEPTION, 2'h1, 5'h00, 10'h0, 10'h27F, 32'h5000, 3'h4};
    rows[2] = '{1'b0, 32'h0, OP_RETURN, 2'h0, 5'h00, 10'h280, 10'h27F, 32'h5000, 3'h2};
    rows[3] = '{1'b1, 32'h5554, OP_RETURN, 2'h0, 5'h00, 10'h100, 10'h100, 32'h3000, 3'h0};
    rows[4] = '{1'b0, 32'h0, OP_INTERRUPT, 2'h0, 5'h02, 10'h0, 10'h002, 32'h1000, 3'h4};
    rows[5] = '{1'b0, 32'h0, OP_EXCEPTION, 2'h2, 5'h00, 10'h0, 10'h002, 32'h1000, 3'h1};
    rows[6] = '{1'b0, 32'h0, OP_EXCEPTION, 2'h3, 5'h00, 10'h0, 10'h002, 32'h1000, 3'h1};
    rows[7] = '{1'b0, 32'h0, OP_INTERRUPT, 2'h1, 5'h05, 10'h0, 10'h205, 32'h5554, 3'h4};
    rows[8] = '{1'b0, 32'h0, OP_EXCEPTION, 2'h0, 5'h00, 10'h0, 10'h205, 32'h5554, 3'h4};
    rows[9] = '{1'b0, 32'h0, OP_RETURN, 2'h0, 5'h00, 10'h180, 10'h180, 32'h4444, 3'h0};
    rows[10] = '{1'b0, 32'h0, OP_EXCEPTION, 2'h0, 5'h00, 10'h0, 10'h060, 32'h1000, 3'h4};
    repeat (6) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("status", 32'h0, 32'(statusWord));
    chk("stack register", 32'h0, generalRegFourteen);
    $display("test reset done");
    for (int i = 0; i < NUM_SP; i++) axw(8'h20 + 8'(4 * i), 32'(i + 1) << 12, RESP_OKAY);
    for (int i = 0; i < NUM_SP; i++) axr(8'h20 + 8'(4 * i), 32'(i + 1) << 12, '1, 2'h0);
    chk("stack register", 32'h1000, generalRegFourteen);
    $display("test pointer access done");
    // table rows: returns, kernel and interrupt stack entries, diverted codes 10 and 11
    for (int i = 0; i < 11; i++) begin
      if (rows[i].we) sq.pulse(3'h2, rows[i].wd);
      sq.send(rq(rows[i].op, rows[i].vec, rows[i].lvl, rows[i].ret));
      #1;
      chk("status", 32'(rows[i].es), 32'(statusWord));
      chk("stack register", rows[i].executive_stack_ptr, generalRegFourteen);
      chk("pulses", 32'(rows[i].ep), 32'(pulseBits));
    end
    $display("test state changes done");
    axr(8'h2C, 32'h4444, '1, RESP_OKAY);
    axr(8'h30, 32'h5554, '1, RESP_OKAY);
    axr(8'h20, 32'h1000, '1, RESP_OKAY);
    sq.pulse(3'h2, 32'h1003);
    #1;
    chk("stack register", 32'h1003, generalRegFourteen);
    sq.pulse(3'h4, 32'h0);
    #1;
    chk("stack register", 32'h1000, generalRegFourteen);
    chk("pushes", 32'h5, 32'(sq.pushCount));
    $display("test saved pointers done");
    sq.pulse(3'h1, 32'h0);
    #1;
    chk("abort", 32'h1, 32'(ksnvAbort));
    chk("status", 32'h21F, 32'(statusWord & 10'h39F));
    chk("stack register", 32'h5554, generalRegFourteen);
    sq.pulse(3'h1, 32'h0);
    #1;
    chk("halt", 32'h1, 32'(haltReq));
    sq.send(rq(OP_RETURN, 2'h0, 5'h00, 10'h000));
    #1;
    chk("status", 32'h21F, 32'(statusWord & 10'h39F));
    axr(REG_STATE, 32'h0400_031F, 32'hFF3F_FFFF, RESP_OKAY);
    axw(REG_CTRL, 32'h1, RESP_OKAY);
    #1;
    chk("halt", 32'h0, 32'(haltReq));
    sq.send(rq(OP_RETURN, 2'h0, 5'h00, 10'h000));
    #1;
    chk("status", 32'h0, 32'(statusWord));
    $display("test stack faults done");
    axr(REG_EVT_STAT, 32'hF, '1, RESP_OKAY);
    chk("irq", 32'h0, 32'(irq));
    axw(REG_EVT_MASK, 32'h2, RESP_OKAY);
    #1;
    chk("irq", 32'h1, 32'(irq));
    axw(REG_EVT_STAT, 32'h2, RESP_OKAY);
    #1;
    chk("irq", 32'h0, 32'(irq));
    axr(REG_EVT_STAT, 32'hD, '1, RESP_OKAY);
    axr(8'h10, 32'h0, '1, RESP_SLVERR);
    axw(8'h14, 32'hFFFF_FFFF, RESP_SLVERR);
    $display("test events and unmapped done");
    @(posedge sys_clk);
    srst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    srst <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk("status", 32'h0, 32'(statusWord));
    chk("stack register", 32'h0, generalRegFourteen);
    chk("halt and irq", 32'h0, 32'({haltReq, irq}));
    $display("test second reset done");
    give_verdict();
  end
endmodule // stack_pointer_select_bench
